// file: rtl/sstrap_top.v
// Operation
// RULE1: host writes straps first, then done bit
// RULE2: done bit fires reset pulse, latches straps
// RULE3: done resets 0; zero means config incomplete
// RULE4: bit 14 crossover enable, default one
// RULE5: crossover value copied to crossover control
// RULE6: enable plus mode decode forced/advertised modes
// RULE7: decoded value written to control, advertise
// RULE8: bit 10 led mode one, default one
// RULE9: led bit latched into led config bit 5
// RULE10: unwritten fields keep and latch defaults
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "sstrap_regs.vh"

module sstrap_top #(
    parameter PULSE_CYCLES = `SSTRAP_RESET_PULSE_CYC
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg         internal_reset_pulse,
    output reg         config_complete,
    output reg         mdix_enable,
    output reg  [15:0] basic_mode_control_reg,
    output reg  [15:0] ability_advertise_reg,
    output reg         led_config_select
);
    localparam ST_WAIT  = 2'd0;
    localparam ST_PULSE = 2'd1;
    localparam ST_DONE  = 2'd2;

    reg  [15:0] soft_strap_control_one;
    reg  [1:0]  state;
    reg  [7:0]  pulse_count;
    reg  [7:0]  aw_addr;
    reg         aw_held;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;
    reg         w_held;
    wire [15:0] dec_mode_ctl;
    wire [15:0] dec_advert;
    wire        negotiation_enable_flag;
    wire [1:0]  negotiation_mode_select;
    wire        do_write;
    wire        write_ok;
    wire [15:0] wr_val;

    function addr_known;
        input [7:0] a;
        begin
            if (a == `SSTRAP_SCR1_ADDR)
                addr_known = 1'b1;
            else if (a == `SSTRAP_STATUS_ADDR)
                addr_known = 1'b1;
            else if (a == `SSTRAP_MODECTL_ADDR)
                addr_known = 1'b1;
            else if (a == `SSTRAP_ADVERT_ADDR)
                addr_known = 1'b1;
            else if (a == `SSTRAP_LEDCFG_ADDR)
                addr_known = 1'b1;
            else
                addr_known = 1'b0;
        end
    endfunction

    assign negotiation_enable_flag = soft_strap_control_one[`SSTRAP_NEGEN_BIT];
    assign negotiation_mode_select = soft_strap_control_one[`SSTRAP_NEGMODE_HI:`SSTRAP_NEGMODE_LO];

    sstrap_decode u_decode (
        .neg_enable   (negotiation_enable_flag), // RULE6
        .neg_mode     (negotiation_mode_select),
        .mode_ctl_val (dec_mode_ctl),
        .advert_val   (dec_advert)
    );

    // write side: address and data held until both present, one response outstanding
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign do_write      = aw_held && w_held && !s_axi_bvalid;
    assign write_ok      = (aw_addr == `SSTRAP_SCR1_ADDR);
    assign wr_val        = {w_strb[1] ? w_data[15:8] : soft_strap_control_one[15:8],
                            w_strb[0] ? w_data[7:0]  : soft_strap_control_one[7:0]};

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 8'h00;
            w_data       <= 32'h00000000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
            soft_strap_control_one <= `SSTRAP_SCR1_RESET; // RULE4 RULE8 RULE10
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= addr_known(aw_addr) ? 2'b00 : 2'b10;
                // lower bits are out of scope and stay zero
                if (write_ok)
                    soft_strap_control_one <= wr_val & `SSTRAP_SCR1_WMASK; // RULE3 RULE4
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // internal reset sequence; a clear of done after completion restarts the wait, while the pulse state ignores done
    always @(posedge aclk) begin
        if (!aresetn) begin
            state                  <= ST_WAIT;
            pulse_count            <= 8'h00;
            internal_reset_pulse   <= 1'b0;
            config_complete        <= 1'b0;
            mdix_enable            <= 1'b1;
            basic_mode_control_reg <= 16'h0000;
            ability_advertise_reg  <= 16'h0000;
            led_config_select      <= 1'b1;
        end else begin
            case (state)
                ST_WAIT: begin
                    // configuration incomplete while done is low
                    if (soft_strap_control_one[`SSTRAP_DONE_BIT]) begin // RULE3
                        state                <= ST_PULSE;
                        pulse_count          <= PULSE_CYCLES[7:0];
                        internal_reset_pulse <= 1'b1; // RULE2
                    end
                end
                ST_PULSE: begin
                    if (pulse_count == 8'h01) begin
                        internal_reset_pulse   <= 1'b0;
                        state                  <= ST_DONE;
                        config_complete        <= 1'b1; // RULE3
                        mdix_enable            <= soft_strap_control_one[`SSTRAP_MDIX_BIT]; // RULE5
                        basic_mode_control_reg <= dec_mode_ctl; // RULE7
                        ability_advertise_reg  <= dec_advert; // RULE7
                        led_config_select      <= soft_strap_control_one[`SSTRAP_LED_BIT]; // RULE9
                    end
                    pulse_count <= pulse_count - 8'h01;
                end
                default: begin
                    // latched values hold; done cleared re-arms a new load
                    if (!soft_strap_control_one[`SSTRAP_DONE_BIT]) begin
                        state           <= ST_WAIT;
                        config_complete <= 1'b0;
                    end
                end
            endcase
        end
    end

    // read side, one read at a time
    assign s_axi_arready = !s_axi_rvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'b00;
            if (s_axi_araddr == `SSTRAP_SCR1_ADDR)
                s_axi_rdata <= {16'h0000, soft_strap_control_one};
            else if (s_axi_araddr == `SSTRAP_STATUS_ADDR)
                s_axi_rdata <= {28'h0000000, led_config_select, mdix_enable,
                                internal_reset_pulse, config_complete};
            else if (s_axi_araddr == `SSTRAP_MODECTL_ADDR)
                s_axi_rdata <= {16'h0000, basic_mode_control_reg};
            else if (s_axi_araddr == `SSTRAP_ADVERT_ADDR)
                s_axi_rdata <= {16'h0000, ability_advertise_reg};
            else if (s_axi_araddr == `SSTRAP_LEDCFG_ADDR)
                s_axi_rdata <= {26'h0, led_config_select, 5'h00};
            else begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= 2'b10;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

`default_nettype wire

// file: rtl/sstrap_regs.vh
`ifndef SSTRAP_REGS_VH
`define SSTRAP_REGS_VH

`define SSTRAP_SCR1_INDEX      4'h9
`define SSTRAP_SCR1_ADDR       8'h24
`define SSTRAP_STATUS_ADDR     8'h40
`define SSTRAP_MODECTL_ADDR    8'h44
`define SSTRAP_ADVERT_ADDR     8'h48
`define SSTRAP_LEDCFG_ADDR     8'h4c

`define SSTRAP_DONE_BIT        15
`define SSTRAP_MDIX_BIT        14
`define SSTRAP_NEGEN_BIT       13
`define SSTRAP_NEGMODE_HI      12
`define SSTRAP_NEGMODE_LO      11
`define SSTRAP_LED_BIT         10

`define SSTRAP_SCR1_RESET      16'h7c00
`define SSTRAP_SCR1_WMASK      16'hfc00

`define SSTRAP_MODECTL_NEGEN_BIT  12
`define SSTRAP_MODECTL_SPEED_BIT  13
`define SSTRAP_MODECTL_DUPLEX_BIT 8
`define SSTRAP_ADVERT_10HD_BIT    5
`define SSTRAP_ADVERT_10FD_BIT    6
`define SSTRAP_ADVERT_100HD_BIT   7
`define SSTRAP_ADVERT_100FD_BIT   8
`define SSTRAP_ADVERT_SEL         16'h0001
`define SSTRAP_MDIX_CTRL_BIT   15
`define SSTRAP_LEDCFG_BIT      5

`define SSTRAP_RESET_PULSE_NS  40
`define SSTRAP_CLK_PERIOD_NS   10
`define SSTRAP_RESET_PULSE_CYC ((`SSTRAP_RESET_PULSE_NS + `SSTRAP_CLK_PERIOD_NS - 1) / `SSTRAP_CLK_PERIOD_NS)

`endif

// file: rtl/sstrap_decode.v
`timescale 1ns/1ps
`default_nettype none
`include "sstrap_regs.vh"

module sstrap_decode (
    input  wire        neg_enable,
    input  wire [1:0]  neg_mode,
    output reg  [15:0] mode_ctl_val,
    output reg  [15:0] advert_val
);
    always @* begin
        mode_ctl_val = 16'h0000;
        advert_val   = `SSTRAP_ADVERT_SEL;
        mode_ctl_val[`SSTRAP_MODECTL_NEGEN_BIT] = neg_enable;
        if (!neg_enable) begin
            mode_ctl_val[`SSTRAP_MODECTL_SPEED_BIT]  = neg_mode[1];
            mode_ctl_val[`SSTRAP_MODECTL_DUPLEX_BIT] = neg_mode[0];
            case (neg_mode)
                2'b00: advert_val[`SSTRAP_ADVERT_10HD_BIT] = 1'b1;
                2'b01: advert_val[`SSTRAP_ADVERT_10FD_BIT] = 1'b1;
                2'b10: advert_val[`SSTRAP_ADVERT_100HD_BIT] = 1'b1;
                default: advert_val[`SSTRAP_ADVERT_100FD_BIT] = 1'b1;
            endcase
        end else begin
            mode_ctl_val[`SSTRAP_MODECTL_SPEED_BIT]  = 1'b1;
            mode_ctl_val[`SSTRAP_MODECTL_DUPLEX_BIT] = 1'b1;
            case (neg_mode)
                2'b00: begin
                    advert_val[`SSTRAP_ADVERT_10HD_BIT] = 1'b1;
                    advert_val[`SSTRAP_ADVERT_10FD_BIT] = 1'b1;
                end
                2'b01: begin
                    advert_val[`SSTRAP_ADVERT_100HD_BIT] = 1'b1;
                    advert_val[`SSTRAP_ADVERT_100FD_BIT] = 1'b1;
                end
                2'b10: begin
                    advert_val[`SSTRAP_ADVERT_10HD_BIT]  = 1'b1;
                    advert_val[`SSTRAP_ADVERT_100HD_BIT] = 1'b1;
                end
                default: begin
                    advert_val[`SSTRAP_ADVERT_10HD_BIT]  = 1'b1;
                    advert_val[`SSTRAP_ADVERT_10FD_BIT]  = 1'b1;
                    advert_val[`SSTRAP_ADVERT_100HD_BIT] = 1'b1;
                    advert_val[`SSTRAP_ADVERT_100FD_BIT] = 1'b1;
                end
            endcase
        end
    end
endmodule

`default_nettype wire

// file: bench/sstrap_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sstrap_asserts #(parameter PULSE_CYCLES = 4) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        internal_reset_pulse,
    input wire logic        config_complete
);
    int unsigned run_len;
    // length of the current pulse so far
    always @(posedge aclk) begin
        if (!aresetn || !internal_reset_pulse) run_len <= 0;
        else run_len <= run_len + 1;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_pulse_end; $fell(internal_reset_pulse); endsequence
    sequence s_aw_w_taken; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
    a_pulse_len: assert property (s_pulse_end |-> run_len == PULSE_CYCLES)
        else $error("reset pulse length wrong");
    a_latch_done: assert property (s_pulse_end |-> config_complete)
        else $error("complete not set at pulse end");
    a_done_cause: assert property ($rose(config_complete) |-> $past(internal_reset_pulse))
        else $error("complete without pulse");
    a_pulse_quiet: assert property (internal_reset_pulse |-> !config_complete)
        else $error("complete during pulse");
    a_write_resp: assert property (s_aw_w_taken |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
        else $error("read data changed");
endmodule
bind sstrap_top sstrap_asserts #(.PULSE_CYCLES(PULSE_CYCLES)) chk_u (.*);
`default_nettype wire

// file: bench/sstrap_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host processor on the register bus; strap order is kept by its caller
module sstrap_host_model (
    input  wire logic        aclk,
    output logic      [7:0]  s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic      [31:0] s_axi_wdata,
    output logic      [3:0]  s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic      [7:0]  s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end
    // released payload is inverted so a stale value is never mistaken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~a;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~d;
            end
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~a;
            end
        end while (!s_axi_rvalid);
        {d, r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: bench/sstrap_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sstrap_regs.vh"
module sstrap_top_tb_top;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [15:0] basic_mode_control_reg, ability_advertise_reg, strap;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, internal_reset_pulse, config_complete, mdix_enable;
    logic led_config_select;
    int err_count = 0, comparisons = 0, cycles = 0;
    localparam logic [15:0] ADV [4] = '{16'h0061, 16'h0181, 16'h00a1, 16'h01e1};
    sstrap_top #(.PULSE_CYCLES(4)) dut_u (.*);
    sstrap_host_model host_u (.*);
    initial begin
        aclk = 0;
        forever #5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            finish_test;
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task finish_test;
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // bounded poll; the clear and latch times are not fixed
    task automatic wait_level(input logic v);
        for (int i = 0; i < 20 && config_complete !== v; i++) @(posedge aclk);
        chk("config_complete", config_complete, v);
    endtask
    task automatic t_reset;
        host_u.rd(`SSTRAP_SCR1_ADDR, rd, rs);
        chk("strap default", rd, 32'h7c00);
        host_u.rd(`SSTRAP_STATUS_ADDR, rd, rs);
        chk("status default", rd, 32'hc);
        host_u.rd(8'h80, rd, rs);
        chk("unmapped resp", rs, 2'b10);
        chk("unmapped data", rd, 32'h0);
    endtask
    task automatic t_defaults;
        host_u.wr(`SSTRAP_SCR1_ADDR, 32'h8000 | `SSTRAP_SCR1_RESET, rs);
        chk("write resp", rs, 2'b00);
        @(posedge aclk);
        chk("reset pulse", internal_reset_pulse, 1'b1);
        chk("complete early", config_complete, 1'b0);
        wait_level(1'b1);
        chk("mode ctl default", basic_mode_control_reg, 16'h3100);
        chk("advert default", ability_advertise_reg, 16'h01e1);
        chk("mdix default", mdix_enable, 1'b1);
        chk("led default", led_config_select, 1'b1);
        host_u.rd(`SSTRAP_MODECTL_ADDR, rd, rs);
        chk("mode ctl read", rd, 32'h3100);
        host_u.rd(`SSTRAP_ADVERT_ADDR, rd, rs);
        chk("advert read", rd, 32'h01e1);
        host_u.rd(`SSTRAP_LEDCFG_ADDR, rd, rs);
        chk("led_config_select read", rd, 32'h20);
        chk("read resp", rs, 2'b00);
    endtask
    task automatic t_codes;
        for (int c = 0; c < 8; c++) begin
            strap = {1'b0, c[0], c[2:0], c[1], 10'h0};
            host_u.wr(`SSTRAP_SCR1_ADDR, 32'h0, rs);
            wait_level(1'b0);
            host_u.wr(`SSTRAP_SCR1_ADDR, {16'h0, strap}, rs);
            wait_level(1'b0);
            host_u.wr(`SSTRAP_SCR1_ADDR, {16'h0, strap | 16'h8000}, rs);
            wait_level(1'b1);
            chk("mdix", mdix_enable, c[0]);
            chk("led", led_config_select, c[1]);
            chk("mode ctl", basic_mode_control_reg,
                c[2] ? 16'h3100 : {2'b0, c[1], 4'b0, c[0], 8'h0});
            chk("advert", ability_advertise_reg,
                c[2] ? ADV[c[1:0]] : 16'h0001 | (16'h0020 << c[1:0]));
            host_u.rd(`SSTRAP_SCR1_ADDR, rd, rs);
            chk("strap readback", rd, {16'h0, strap | 16'h8000});
        end
    endtask
    initial begin
        aresetn = 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_defaults;
        t_codes;
        finish_test;
    end
endmodule
`default_nettype wire
